// ---- tb/psc_link_monitor.sv ----
// Purpose: protocol checks on the multiplexed link
// Assumes: one clock, synchronous active-high reset
// Notes: sees the interface signals only
`timescale 1ns/1ns
module psc_link_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic mad_ctl_oe,
    input wire logic mad_dev_oe,
    input wire logic stall
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // minimum latency of a synchronous access
    sequence s_lat;
        stall [*3];
    endsequence
    // data line ownership, one driver at a time
    a_read_drive: assert property
        ($fell(oe_n) && !ce_n |-> ##[1:8] mad_dev_oe)
        else $error("no read data after output enable");
    a_write_quiet: assert property
        (!we_n && $past(!we_n) |-> !mad_dev_oe)
        else $error("device drives during a write");
    a_one_driver: assert property
        (!(mad_dev_oe && mad_ctl_oe))
        else $error("both ends drive the data lines");
    a_idle_quiet: assert property
        (ce_n && $past(ce_n) |-> !mad_dev_oe && !stall)
        else $error("device active while deselected");
    // stall is bounded, and refresh only lengthens it
    a_stall_min: assert property
        ($rose(stall) |-> s_lat)
        else $error("stall shorter than the latency");
    a_stall_max: assert property
        ($rose(stall) |-> ##[1:40] !stall)
        else $error("stall never ends");
    a_stall_ce: assert property
        (stall |-> !ce_n)
        else $error("chip enable released during stall");
    a_stall_data: assert property
        ($fell(stall) && we_n |-> mad_dev_oe)
        else $error("no data when stall ends");
endmodule : psc_link_monitor

// ---- tb/psram_config_register_access_tb.sv ----
// Purpose: bench for both ends of the register access link
// Assumes: 25 MHz clock, reset held three cycles
// Notes: every scenario runs whole controller accesses
`timescale 1ns/1ns
`include "psc_cfg.svh"
module psram_config_register_access_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, busy_i = 1'h0;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [15:0] bus_cfg, ref_cfg;
    int errors = 0, samples_checked = 0;
    psc_link_if psc_link_if_inst ();
    psc_dev_end #(.DEV_ID(16'h3c96)) psc_dev_end_inst (.clk_i(clk_i),
        .rst_i(rst_i), .link(psc_link_if_inst), .refresh_busy_i(busy_i),
        .bus_cfg_o(bus_cfg), .ref_cfg_o(ref_cfg));
    psc_ctl_end psc_ctl_end_inst (.clk_i(clk_i), .rst_i(rst_i),
        .link(psc_link_if_inst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    psc_link_monitor psc_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ce_n(psc_link_if_inst.ce_n), .we_n(psc_link_if_inst.we_n),
        .oe_n(psc_link_if_inst.oe_n),
        .mad_ctl_oe(psc_link_if_inst.mad_ctl_oe),
        .mad_dev_oe(psc_link_if_inst.mad_dev_oe),
        .stall(psc_link_if_inst.stall));
    ////////////////////////////////////////
    initial forever #20 clk_i = ~clk_i;
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        tally_and_finish;
    end
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // classic cycle: hold until ack, release after it
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    // one controller go; busy is polled so no latency is assumed
    task automatic acc(logic [23:0] a, logic [15:0] d, logic [7:0] c);
        wb(1'h1, `PSC_WB_ADDR, {8'h00, a});
        wb(1'h1, `PSC_WB_WDATA, {16'h0000, d});
        wb(1'h1, `PSC_WB_CTRL, {24'h00_0000, c});
        q[`PSC_CT_BUSY] = 1'h1;
        while (q[`PSC_CT_BUSY] !== 1'h0)
            wb(1'h0, `PSC_WB_CTRL, 32'h0000_0000);
        wb(1'h0, `PSC_WB_RDATA, 32'h0000_0000);
    endtask : acc
    task automatic t_reset;
        chk("bus cfg", bus_cfg, 16'h9d1f);
        acc({4'h0, 2'h2, 18'h0_0000}, 16'h0000, 8'h05);
        chk("bus read", q[15:0], 16'h9d1f);
        $display("reset test done");
    endtask : t_reset
    // register path: refresh write, identity write refused
    task automatic t_cre;
        acc({4'h0, 2'h0, 2'h0, 16'h0012}, 16'h0000, 8'h07);
        chk("ref cfg", ref_cfg, 16'h0012);
        acc({4'h0, 2'h1, 2'h0, 16'h0000}, 16'h0000, 8'h07);
        acc({4'h0, 2'h1, 18'h0_0000}, 16'h0000, 8'h05);
        chk("id read", q[15:0], 16'h3c96);
        $display("register path test done");
    endtask : t_cre
    // synchronous read stretched by a refresh collision
    task automatic t_sync;
        acc({4'h0, 2'h2, 2'h0, 16'h1d1f}, 16'h0000, 8'h07);
        fork
            acc({4'h0, 2'h0, 18'h0_0000}, 16'h0000, 8'h0d);
            begin
                @(posedge clk_i iff psc_link_if_inst.stall);
                busy_i <= 1'h1;
                repeat (4) @(posedge clk_i);
                busy_i <= 1'h0;
            end
        join
        chk("sync read", q[15:0], 16'h0012);
        acc({4'h0, 2'h2, 2'h0, 16'h9d1f}, 16'h0000, 8'h0f);
        chk("async mode", bus_cfg, 16'h9d1f);
        $display("sync test done");
    endtask : t_sync
    // software sequence at the top address, both targets
    task automatic t_sw;
        acc(`PSC_TOP_ADDR, 16'hbeef, 8'h03);
        acc(`PSC_TOP_ADDR, 16'h9d17, 8'h33);
        chk("sw bus", bus_cfg, 16'h9d17);
        acc(`PSC_TOP_ADDR, 16'h0014, 8'h13);
        chk("sw ref", ref_cfg, 16'h0014);
        acc(`PSC_TOP_ADDR, 16'h0000, 8'h31);
        chk("sw read", q[15:0], 16'h9d17);
        acc({4'h0, 2'h2, 18'h0_0000}, 16'h0000, 8'h05);
        chk("readback", q[15:0], 16'h9d17);
        acc(`PSC_TOP_ADDR, 16'h0000, 8'h01);
        chk("top word", q[15:0], 16'hbeef);
        $display("software test done");
    endtask : t_sw
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_cre;
        t_sync;
        t_sw;
        tally_and_finish;
    end
endmodule : psram_config_register_access_tb

// ---- verilog/psc_cfg.svh ----
// Purpose: constants of the pseudo-static RAM register access block
// Assumes: 25 MHz system clock shared by both ends
// Notes: definitions only
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_AW 24
`define PSC_TOP_ADDR 24'hff_ffff
`define PSC_BUS_CFG_RST 16'h9d1f
`define PSC_REF_CFG_RST 16'h0010
`define PSC_SEL_BUS 2'h2
`define PSC_SEL_REF 2'h0
`define PSC_SEL_ID 2'h1
`define PSC_SW_SEL_REF 16'h0000
`define PSC_SW_SEL_BUS 16'h0001
`define PSC_BC_MODE 15
`define PSC_BC_NOWRAP 3
`define PSC_BL_4 3'h1
`define PSC_BL_8 3'h2
`define PSC_BL_16 3'h3
`define PSC_BL_32 3'h4
`define PSC_LAT_CYC 3
`define PSC_CLK_NS 40
`define PSC_T_ACC_NS 70
`define PSC_ACC_CYC ((`PSC_T_ACC_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_WB_ADDR 8'h00
`define PSC_WB_WDATA 8'h04
`define PSC_WB_CTRL 8'h08
`define PSC_WB_RDATA 8'h0c
`define PSC_CT_GO 0
`define PSC_CT_BUSY 8
`endif

// ---- verilog/psc_ctl_end.sv ----
// Purpose: memory controller end, ordered over classic Wishbone
// Assumes: link on the same clock as the bus
// Notes: one go may run up to four link accesses; busy stays high until the last is finished
`timescale 1ns/1ns
`include "psc_cfg.svh"
module psc_ctl_end (
    input wire logic clk_i,
    input wire logic rst_i,
    psc_link_if.ctl link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    psc_pkg::psc_ctl_s q;
    psc_pkg::psc_ctl_s d;
    logic req;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        req = wb_cyc_i && wb_stb_i;
        // slave: ack one cycle after the strobe, write at the ack edge
        d.ack = req && !q.ack;
        if (req && !q.ack)
        begin
            if (wb_adr_i == `PSC_WB_ADDR)
                d.wb_dat = {8'h00, q.u_addr};
            else if (wb_adr_i == `PSC_WB_WDATA)
                d.wb_dat = {16'h0000, q.u_wdata};
            else if (wb_adr_i == `PSC_WB_CTRL)
                d.wb_dat = {23'h00_0000, q.busy, 2'h0, q.u_ctrl, 1'b0};
            else if (wb_adr_i == `PSC_WB_RDATA)
                d.wb_dat = {16'h0000, q.rdata};
            else
                d.wb_dat = 32'h0000_0000;
        end
        if (req && q.ack && wb_we_i)
        begin
            if (wb_adr_i == `PSC_WB_ADDR)
                d.u_addr = 24'(merge({8'h00, q.u_addr}, wb_dat_i,
                                     wb_sel_i));
            else if (wb_adr_i == `PSC_WB_WDATA)
                d.u_wdata = 16'(merge({16'h0000, q.u_wdata}, wb_dat_i,
                                      wb_sel_i));
            else if (wb_adr_i == `PSC_WB_CTRL && wb_sel_i[0] && !q.busy)
            begin
                d.u_ctrl = wb_dat_i[5:1];
                // go is refused while busy
                if (wb_dat_i[`PSC_CT_GO])
                begin
                    d.busy = 1'b1;
                    d.pend = 1'b1;
                    d.sw = wb_dat_i[4];
                    d.sw_step = 2'h0;
                    d.dummy = 1'b0;
                    d.oa = wb_dat_i[4] ? `PSC_TOP_ADDR : q.u_addr;
                    d.od = q.u_wdata;
                    d.owe = wb_dat_i[1] && !wb_dat_i[4];
                    d.ors = wb_dat_i[2] && !wb_dat_i[4];
                    d.osync = wb_dat_i[3] && !wb_dat_i[4];
                end
            end
        end
        case (q.st)
            psc_pkg::PSC_C_IDLE:
            begin
                // R23 a new access only starts from standby
                if (q.pend)
                begin
                    d.pend = 1'b0;
                    d.ce_n = 1'b0;
                    d.av_n = 1'b0;
                    d.bm_n = 1'b0;
                    d.rs = q.ors;
                    // R03 value rides on the address phase
                    d.a_hi = q.oa[23:16];
                    d.dq = q.oa[15:0];
                    d.dq_oe = 1'b1;
                    d.we_n = !(q.owe && q.osync);
                    d.st = q.osync ? psc_pkg::PSC_C_SADR
                                   : psc_pkg::PSC_C_AADR;
                end
            end
            psc_pkg::PSC_C_AADR:
            begin
                d.av_n = 1'b1;
                d.cnt = 4'(`PSC_ACC_CYC);
                d.dq = q.od;
                d.dq_oe = q.owe;
                d.we_n = !q.owe;
                d.oe_n = q.owe;
                d.st = q.owe ? psc_pkg::PSC_C_AWR : psc_pkg::PSC_C_ARD;
            end
            psc_pkg::PSC_C_ARD, psc_pkg::PSC_C_AWR:
            begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt <= 4'h1)
                begin
                    if (q.st == psc_pkg::PSC_C_ARD && !q.dummy)
                        d.rdata = link.mad;
                    d.oe_n = 1'b1;
                    d.we_n = 1'b1;
                    d.st = psc_pkg::PSC_C_AREL;
                end
            end
            psc_pkg::PSC_C_SADR:
            begin
                d.av_n = 1'b1;
                d.dq = q.od;
                d.dq_oe = q.owe;
                d.cnt = 4'h1;
                d.st = psc_pkg::PSC_C_SWAIT;
            end
            psc_pkg::PSC_C_SWAIT:
            begin
                // R07 R08 chip enable stays low while stalled
                if (q.cnt != 4'h0)
                    d.cnt = 4'h0;
                else if (!link.stall)
                begin
                    if (q.we_n && !q.dummy)
                        d.rdata = link.mad;
                    d.st = psc_pkg::PSC_C_AREL;
                end
            end
            default:
            begin
                d.st = psc_pkg::PSC_C_IDLE;
            end
        endcase
        if (q.st == psc_pkg::PSC_C_AREL)
        begin
            d.ce_n = 1'b1;
            d.we_n = 1'b1;
            d.oe_n = 1'b1;
            d.bm_n = 1'b1;
            d.dq_oe = 1'b0;
            d.st = psc_pkg::PSC_C_IDLE;
            // R09 R10 R12 software sequence on the top address
            if (q.sw && q.sw_step != 2'h3)
            begin
                d.sw_step = q.sw_step + 2'h1;
                d.owe = q.sw_step != 2'h0 && (q.sw_step == 2'h1
                                             || q.u_ctrl[1]);
                d.od = q.sw_step == 2'h1
                    ? (q.u_ctrl[5] ? `PSC_SW_SEL_BUS : `PSC_SW_SEL_REF)
                    : q.u_wdata;
                d.pend = 1'b1;
            end
            // R06 array read right after a register access
            else if (q.ors && !q.dummy)
            begin
                d.dummy = 1'b1;
                d.ors = 1'b0;
                d.owe = 1'b0;
                d.pend = 1'b1;
            end
            else
                d.busy = 1'b0;
        end
        // SWAIT hand-off raises ce as it enters the release state
        if (q.st == psc_pkg::PSC_C_SWAIT && d.st == psc_pkg::PSC_C_AREL)
            d.ce_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.st <= psc_pkg::PSC_C_IDLE;
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.av_n <= 1'b1;
            q.bm_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.ack;
    assign link.ce_n = q.ce_n;
    assign link.we_n = q.we_n;
    assign link.oe_n = q.oe_n;
    assign link.addr_valid_n = q.av_n;
    assign link.low_byte_mask_n = q.bm_n;
    assign link.upper_byte_mask_n = q.bm_n;
    assign link.reg_select = q.rs;
    assign link.a_hi = q.a_hi;
    assign link.mad_ctl = q.dq;
    assign link.mad_ctl_oe = q.dq_oe;

endmodule : psc_ctl_end

// ---- verilog/psc_dev_end.sv ----
// Purpose: RAM side: configuration registers, software sequence, bursts
// Assumes: bus inputs are made by logic on clk_i, so none is synchronised
// Notes: the array is a small model; upper address bits alias onto it
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "psc_cfg.svh"

// Behaviour
// R01: register select high routes to registers
// R02: bits 19:18 pick bus, refresh, identity
// R03: controller puts register value on address
// R04: async register write latched at first rise
// R05: register read drives 16 bits, ignores address
// R06: controller reads array after register access
// R07: controller keeps chip enable low through burst
// R08: stall extends sync access; controller follows
// R09: two reads, two writes load a register
// R10: fourth operation a read returns register
// R11: sequence uses top address, array unchanged
// R12: third data 0000h refresh, 0001h bus
// R13: fourth operation moves 16 data bits
// R14: software sequence coexists with register select
// R15: bus configuration resets to 9D1Fh
// R16: reserved bits written zero, read back
// R17: burst settings apply to reads and writes
// R18: burst length 4,8,16,32 or continuous
// R19: continuous burst rolls over to zero
// R20: wrap keeps burst inside aligned block
// R21: no wrap increments linearly
// R22: bit 15 picks synchronous or asynchronous
// R23: controller updates registers only in standby
// R24: identity register ignores every write
module psc_dev_end #(
    parameter int LAT_CYC = `PSC_LAT_CYC,
    parameter int MEM_AW = 6,
    // arbitrary identity value
    parameter logic [15:0] DEV_ID = 16'h0a5c
) (
    input wire logic clk_i,
    input wire logic rst_i,
    psc_link_if.dev link,
    input wire logic refresh_busy_i,
    output logic [15:0] bus_cfg_o,
    output logic [15:0] ref_cfg_o
);

    psc_pkg::psc_dev_s q;
    psc_pkg::psc_dev_s d;
    logic [15:0] mem [2**MEM_AW];
    logic mem_we;
    logic [15:0] mem_wd;
    logic reg_we;
    logic [1:0] reg_wsel;
    logic [15:0] reg_wval;
    logic top_hit;
    logic rise;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [5:0] burst_words(input logic [2:0] code);
        // R18 length decode
        case (code)
            `PSC_BL_4: burst_words = 6'h04;
            `PSC_BL_8: burst_words = 6'h08;
            `PSC_BL_16: burst_words = 6'h10;
            `PSC_BL_32: burst_words = 6'h20;
            default: burst_words = 6'h00;
        endcase
    endfunction : burst_words

    function automatic logic [23:0] next_addr(input logic [23:0] a,
                                             input logic [15:0] bc);
        logic [23:0] m;
        logic [23:0] inc;
        m = {18'h0_0000, burst_words(bc[2:0])} - 24'h00_0001;
        inc = a + 24'h00_0001;
        // R19 R21 linear, wraps past last address
        if (bc[`PSC_BC_NOWRAP] || burst_words(bc[2:0]) == 6'h00)
        begin
            next_addr = inc;
        end
        // R20 modulo inside aligned block
        else
        begin
            next_addr = (a & ~m) | (inc & m);
        end
    endfunction : next_addr

    function automatic logic [15:0] word_at(input logic [23:0] a,
                                            input logic rs);
        // R02 R05 only bits 19:18 pick the register
        if (rs)
        begin
            if (a[19:18] == `PSC_SEL_BUS)
                word_at = q.bus_cfg;
            else if (a[19:18] == `PSC_SEL_REF)
                word_at = q.ref_cfg;
            else if (a[19:18] == `PSC_SEL_ID)
                word_at = DEV_ID;
            else
                word_at = 16'h0000;
        end
        // R10 R13 fourth read of the sequence
        else if (a == `PSC_TOP_ADDR && q.sw_step == 2'h3)
            word_at = q.sw_bus ? q.bus_cfg : q.ref_cfg;
        else
            word_at = mem[a[MEM_AW-1:0]];
    endfunction : word_at

    ////////////////////////////////////////////////////////////////////
    // next state

    // one process decides the whole next state, memory strobes included
    always_comb
    begin
        d = q;
        mem_we = 1'b0;
        mem_wd = {link.upper_byte_mask_n ? mem[q.addr[MEM_AW-1:0]][15:8]
                                         : q.p_dq[15:8],
                  link.low_byte_mask_n ? mem[q.addr[MEM_AW-1:0]][7:0]
                                       : q.p_dq[7:0]};
        reg_we = 1'b0;
        reg_wsel = q.addr[19:18];
        reg_wval = q.addr[15:0];
        top_hit = q.addr == `PSC_TOP_ADDR;
        rise = (link.ce_n && !q.p_ce) || (link.we_n && !q.p_we)
            || (link.addr_valid_n && !q.p_av);
        d.p_ce = link.ce_n;
        d.p_we = link.we_n;
        d.p_av = link.addr_valid_n;
        d.p_dq = link.mad;
        case (q.st)
            psc_pkg::PSC_D_IDLE:
            begin
                d.dq_oe = 1'b0;
                d.stall = 1'b0;
                if (!link.ce_n && !link.addr_valid_n)
                begin
                    d.addr = {link.a_hi, link.mad};
                    // R01 R14 either path may open the access
                    d.rsel = link.reg_select;
                    d.done = 1'b0;
                    // R22 mode bit set means asynchronous, the default
                    if (!q.bus_cfg[`PSC_BC_MODE])
                    begin
                        d.st = psc_pkg::PSC_D_LAT;
                        d.cnt = 4'(LAT_CYC);
                        d.stall = 1'b1;
                        d.left = burst_words(q.bus_cfg[2:0]);
                    end
                    else
                    begin
                        d.st = psc_pkg::PSC_D_ASYNC;
                    end
                end
            end
            psc_pkg::PSC_D_ASYNC:
            begin
                d.dq_oe = !link.oe_n && link.we_n;
                d.dq = word_at(q.addr, q.rsel);
                // R04 first rising edge, byte masks ignored
                if (q.rsel && !q.done && rise
                    && (!link.we_n || !q.p_we))
                begin
                    d.done = 1'b1;
                    reg_we = 1'b1;
                end
                else if (!q.rsel && !q.done && !q.p_we
                         && (link.we_n || link.ce_n))
                begin
                    d.done = 1'b1;
                    // R11 R12 sequence writes never reach the array
                    if (top_hit && q.sw_step == 2'h2
                        && (q.p_dq == `PSC_SW_SEL_REF
                            || q.p_dq == `PSC_SW_SEL_BUS))
                    begin
                        d.sw_bus = q.p_dq == `PSC_SW_SEL_BUS;
                        d.sw_step = 2'h3;
                    end
                    // R09 R13 fourth write loads the register
                    else if (top_hit && q.sw_step == 2'h3)
                    begin
                        reg_we = 1'b1;
                        reg_wsel = q.sw_bus ? `PSC_SEL_BUS : `PSC_SEL_REF;
                        reg_wval = q.p_dq;
                        d.sw_step = 2'h0;
                    end
                    else
                    begin
                        mem_we = 1'b1;
                        d.sw_step = 2'h0;
                    end
                end
                if (link.ce_n)
                begin
                    d.st = psc_pkg::PSC_D_IDLE;
                    d.dq_oe = 1'b0;
                    // R09 R10 reads advance the first two steps
                    if (!q.rsel && !q.done)
                    begin
                        d.sw_step = (top_hit && q.sw_step < 2'h2)
                            ? q.sw_step + 2'h1 : 2'h0;
                    end
                end
            end
            psc_pkg::PSC_D_LAT:
            begin
                // R08 refresh collision holds the stall
                if (!refresh_busy_i)
                    d.cnt = q.cnt - 4'h1;
                if (q.cnt <= 4'h1 && !refresh_busy_i)
                begin
                    d.st = psc_pkg::PSC_D_DATA;
                    d.stall = 1'b0;
                    d.dq = word_at(q.addr, q.rsel);
                    d.dq_oe = link.we_n;
                end
                // a cut access releases the bus at once
                if (link.ce_n)
                begin
                    d.st = psc_pkg::PSC_D_IDLE;
                    d.stall = 1'b0;
                    d.dq_oe = 1'b0;
                end
            end
            psc_pkg::PSC_D_DATA:
            begin
                // R17 one address walk serves reads and writes
                d.addr = next_addr(q.addr, q.bus_cfg);
                d.dq = word_at(d.addr, q.rsel);
                d.dq_oe = link.we_n;
                if (!link.we_n && q.rsel)
                    reg_we = 1'b1;
                else if (!link.we_n)
                begin
                    mem_we = 1'b1;
                    mem_wd = link.mad;
                end
                if (q.rsel || q.left == 6'h01)
                begin
                    d.st = psc_pkg::PSC_D_END;
                    d.dq_oe = 1'b0;
                end
                else if (q.left != 6'h00)
                    d.left = q.left - 6'h01;
                if (link.ce_n)
                begin
                    d.st = psc_pkg::PSC_D_IDLE;
                    d.dq_oe = 1'b0;
                end
            end
            psc_pkg::PSC_D_END:
            begin
                d.dq_oe = 1'b0;
                if (link.ce_n)
                    d.st = psc_pkg::PSC_D_IDLE;
            end
            default:
            begin
                d.st = psc_pkg::PSC_D_IDLE;
            end
        endcase
        // R16 R24 all bits stored as written, identity never written
        if (reg_we && reg_wsel == `PSC_SEL_BUS)
            d.bus_cfg = reg_wval;
        else if (reg_we && reg_wsel == `PSC_SEL_REF)
            d.ref_cfg = reg_wval;
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.st <= psc_pkg::PSC_D_IDLE;
            // R15 power-up values
            q.bus_cfg <= `PSC_BUS_CFG_RST;
            q.ref_cfg <= `PSC_REF_CFG_RST;
            q.p_ce <= 1'b1;
            q.p_we <= 1'b1;
            q.p_av <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // array has no reset; its contents are undefined after power-up
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
            mem[q.addr[MEM_AW-1:0]] <= mem_wd;
    end

    assign link.mad_dev = q.dq;
    assign link.mad_dev_oe = q.dq_oe;
    assign link.stall = q.stall;
    assign bus_cfg_o = q.bus_cfg;
    assign ref_cfg_o = q.ref_cfg;

endmodule : psc_dev_end

// ---- verilog/psc_link_if.sv ----
// Purpose: multiplexed bus between memory controller and the RAM
// Assumes: both ends run on the same clock
// Notes: the shared data wire reads all ones when nobody drives it
`timescale 1ns/1ns
interface psc_link_if;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic addr_valid_n;
    logic low_byte_mask_n;
    logic upper_byte_mask_n;
    logic reg_select;
    logic [7:0] a_hi;
    logic [15:0] mad_ctl;
    logic mad_ctl_oe;
    logic [15:0] mad_dev;
    logic mad_dev_oe;
    logic stall;
    logic [15:0] mad;

    // wire resolution: the device wins, then the controller, a weak pull-up otherwise
    assign mad = mad_dev_oe ? mad_dev : (mad_ctl_oe ? mad_ctl : 16'hffff);

    modport dev (
        input ce_n, we_n, oe_n, addr_valid_n, low_byte_mask_n,
        input upper_byte_mask_n, reg_select, a_hi, mad,
        output mad_dev, mad_dev_oe, stall
    );
    modport ctl (
        output ce_n, we_n, oe_n, addr_valid_n, low_byte_mask_n,
        output upper_byte_mask_n, reg_select, a_hi, mad_ctl, mad_ctl_oe,
        input mad, stall
    );
endinterface : psc_link_if

// ---- verilog/psc_pkg.sv ----
// Purpose: types of the pseudo-static RAM register access block
// Assumes: constants come from psc_cfg.svh
// Notes: one-hot state codes
package psc_pkg;

    typedef enum logic [4:0] {
        PSC_D_IDLE = 5'h01,
        PSC_D_ASYNC = 5'h02,
        PSC_D_LAT = 5'h04,
        PSC_D_DATA = 5'h08,
        PSC_D_END = 5'h10
    } psc_dev_e;

    typedef enum logic [6:0] {
        PSC_C_IDLE = 7'h01,
        PSC_C_AADR = 7'h02,
        PSC_C_ARD = 7'h04,
        PSC_C_AWR = 7'h08,
        PSC_C_AREL = 7'h10,
        PSC_C_SADR = 7'h20,
        PSC_C_SWAIT = 7'h40
    } psc_ctl_e;

    typedef struct packed {
        psc_dev_e st;
        logic [15:0] bus_cfg;
        logic [15:0] ref_cfg;
        logic [23:0] addr;
        logic rsel;
        logic done;
        logic p_ce;
        logic p_we;
        logic p_av;
        logic [15:0] p_dq;
        logic [3:0] cnt;
        logic [5:0] left;
        logic [1:0] sw_step;
        logic sw_bus;
        logic [15:0] dq;
        logic dq_oe;
        logic stall;
    } psc_dev_s;

    typedef struct packed {
        psc_ctl_e st;
        logic ack;
        logic [31:0] wb_dat;
        logic [23:0] u_addr;
        logic [15:0] u_wdata;
        logic [5:1] u_ctrl;
        logic [15:0] rdata;
        logic busy;
        logic pend;
        logic [23:0] oa;
        logic [15:0] od;
        logic owe;
        logic ors;
        logic osync;
        logic sw;
        logic [1:0] sw_step;
        logic dummy;
        logic [3:0] cnt;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic av_n;
        logic bm_n;
        logic rs;
        logic [7:0] a_hi;
        logic [15:0] dq;
        logic dq_oe;
    } psc_ctl_s;

endpackage : psc_pkg
